// ===== src/write_protect_cmd_fsm.sv
// Purpose: decodes the vendor write-protect command and tracks protection
// Assumes: cmdValid pulses once per command after all taskfile bytes are written
// Notes: pin/switch sampled at power-up only; writes are swallowed while protected
//
// Overview of operation
// - command register value c2h selects the vendor protection command.
// - the command ends with status only, no data phase.
// - the sector count holds the sub-function: 12 on, 13 off, 15 permanent.
// - codes 22 and 23 carry a 32-bit password from feature, sector number, cylinder low and high.
// - from normal, 12 protects, 15 makes permanent, 22 protects with password; 13 and 23 do nothing.
// - from plain protection, 13 and 23 go normal; 12, 15 and 22 do nothing.
// - in password protection 23 with the right password goes normal, wrong password or 13 errors.
// - permanent protection ignores every code.
// - identify word 129 bit 8 is one whenever any protection is active.
// - the protect pin and switch are looked at only at power-up; low means protect.
// - while protected, writes complete normally but data is dropped.
// - request sense right after an aborted write returns extended code 27h.
module write_protect_cmd_fsm (
  input wire logic clk,
  input wire logic rst,
  input wire logic cmdValid,
  input wire logic [7:0] cmdOpcode,
  input wire logic [7:0] featureReg,
  input wire logic [7:0] sectorCount,
  input wire logic [7:0] sectorNumber,
  input wire logic [7:0] cylLow,
  input wire logic [7:0] cylHigh,
  input wire logic protectPinN,
  input wire logic protectSwitchN,
  input wire logic writeAborted,
  input wire logic [1:0] nvStateIn,
  input wire logic [31:0] nvPwIn,
  output logic nvWrite,
  output logic [1:0] nvStateOut,
  output logic [31:0] nvPwOut,
  output logic cmdDone,
  output logic cmdHandled,
  output logic [7:0] statusOut,
  output logic [7:0] errorOut,
  output logic writeDiscard,
  output logic [15:0] identWord129,
  output logic protectActive
);
  nv_if nv();

  wp_nv_keeper keeper (
    .clk(clk),
    .rst(rst),
    .nvStateIn(nvStateIn),
    .nvPwIn(nvPwIn),
    .nvWrite(nvWrite),
    .nvStateOut(nvStateOut),
    .nvPwOut(nvPwOut),
    .nv(nv)
  );

  logic pinMeta_r;
  logic pinSync_r;
  logic swMeta_r;
  logic swSync_r;
  logic [1:0] boot_r;
  logic [1:0] boot_nxt;
  logic hwProt_r;
  logic hwProt_nxt;
  wp_cmd_pkg::wp_state_t st_r;
  wp_cmd_pkg::wp_state_t st_nxt;
  logic [31:0] pw_r;
  logic [31:0] pw_nxt;
  logic done_r;
  logic done_nxt;
  logic handled_r;
  logic handled_nxt;
  logic [7:0] stat_r;
  logic [7:0] stat_nxt;
  logic [7:0] err_r;
  logic [7:0] err_nxt;
  logic lastAbort_r;
  logic lastAbort_nxt;
  logic save_r;
  logic save_nxt;
  logic [31:0] pwIn;

  always_ff @(posedge clk) begin
    if (rst) begin
      pinMeta_r <= 1'b1;
      pinSync_r <= 1'b1;
      swMeta_r <= 1'b1;
      swSync_r <= 1'b1;
    end else begin
      pinMeta_r <= protectPinN;
      pinSync_r <= pinMeta_r;
      swMeta_r <= protectSwitchN;
      swSync_r <= swMeta_r;
    end
  end

  assign pwIn = {cylHigh, cylLow, sectorNumber, featureReg};

  always_comb begin
    boot_nxt = boot_r;
    hwProt_nxt = hwProt_r;
    st_nxt = st_r;
    pw_nxt = pw_r;
    done_nxt = 1'b0;
    handled_nxt = 1'b0;
    stat_nxt = stat_r;
    err_nxt = err_r;
    lastAbort_nxt = lastAbort_r;
    save_nxt = 1'b0;
    // boot counts past the synchroniser delay and the nv load
    if (boot_r != 2'h3) begin
      boot_nxt = boot_r + 2'h1;
    end
    if (boot_r == 2'h2) begin
      hwProt_nxt = !pinSync_r || !swSync_r;
      st_nxt = nv.loadState;
      pw_nxt = nv.loadPw;
    end
    if (writeAborted) begin
      lastAbort_nxt = 1'b1;
    end
    if (cmdValid && boot_r == 2'h3) begin
      lastAbort_nxt = writeAborted;
      if (cmdOpcode == wp_cmd_pkg::OPC_PROTECT) begin
        done_nxt = 1'b1;
        handled_nxt = 1'b1;
        stat_nxt = wp_cmd_pkg::STAT_OK;
        err_nxt = wp_cmd_pkg::ERR_NONE;
        case (st_r)
          wp_cmd_pkg::WP_NORMAL: begin
            if (sectorCount == wp_cmd_pkg::SUB_ON) begin
              st_nxt = wp_cmd_pkg::WP_PLAIN;
            end else if (sectorCount == wp_cmd_pkg::SUB_PERM) begin
              st_nxt = wp_cmd_pkg::WP_PERMANENT;
            end else if (sectorCount == wp_cmd_pkg::SUB_PW_ON) begin
              st_nxt = wp_cmd_pkg::WP_PASSWORD;
              pw_nxt = pwIn;
            end
          end
          wp_cmd_pkg::WP_PLAIN: begin
            if (sectorCount == wp_cmd_pkg::SUB_OFF || sectorCount == wp_cmd_pkg::SUB_PW_OFF) begin
              st_nxt = wp_cmd_pkg::WP_NORMAL;
            end
          end
          wp_cmd_pkg::WP_PASSWORD: begin
            if (sectorCount == wp_cmd_pkg::SUB_PW_OFF && pwIn == pw_r) begin
              st_nxt = wp_cmd_pkg::WP_NORMAL;
            end else if (sectorCount == wp_cmd_pkg::SUB_PW_OFF || sectorCount == wp_cmd_pkg::SUB_OFF) begin
              stat_nxt = wp_cmd_pkg::STAT_ERR;
              err_nxt = wp_cmd_pkg::ERR_ABORT;
            end
          end
          wp_cmd_pkg::WP_PERMANENT: begin
          end
          default: begin
            st_nxt = wp_cmd_pkg::WP_NORMAL;
          end
        endcase
        save_nxt = 1'b1;
      end else if (cmdOpcode == wp_cmd_pkg::OPC_SENSE) begin
        done_nxt = 1'b1;
        handled_nxt = 1'b1;
        stat_nxt = wp_cmd_pkg::STAT_OK;
        err_nxt = lastAbort_r ? wp_cmd_pkg::SENSE_WP_CODE : wp_cmd_pkg::ERR_NONE;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      boot_r <= 2'h0;
      hwProt_r <= 1'b0;
      st_r <= wp_cmd_pkg::WP_NORMAL;
      pw_r <= wp_cmd_pkg::PW_RESET;
      done_r <= 1'b0;
      handled_r <= 1'b0;
      stat_r <= wp_cmd_pkg::STAT_OK;
      err_r <= wp_cmd_pkg::ERR_NONE;
      lastAbort_r <= 1'b0;
      save_r <= 1'b0;
    end else begin
      boot_r <= boot_nxt;
      hwProt_r <= hwProt_nxt;
      st_r <= st_nxt;
      pw_r <= pw_nxt;
      done_r <= done_nxt;
      handled_r <= handled_nxt;
      stat_r <= stat_nxt;
      err_r <= err_nxt;
      lastAbort_r <= lastAbort_nxt;
      save_r <= save_nxt;
    end
  end

  // save the settled state one cycle after the command
  assign nv.save = save_r;
  assign nv.saveState = st_r;
  assign nv.savePw = pw_r;

  assign cmdDone = done_r;
  assign cmdHandled = handled_r;
  assign statusOut = stat_r;
  assign errorOut = err_r;
  assign protectActive = hwProt_r || (st_r != wp_cmd_pkg::WP_NORMAL);
  assign writeDiscard = protectActive;
  always_comb begin
    identWord129 = 16'h0000;
    identWord129[wp_cmd_pkg::ID_BIT_WP] = protectActive;
  end
endmodule

// ===== common/wp_cmd_pkg.sv
// Purpose: shared constants and types for the write-protect command block
// Assumes: taskfile bytes arrive already latched by the host interface logic
// Notes: state codes follow declaration order, 0 to 3, and are stored as is in the nv array
package wp_cmd_pkg;
  localparam logic [7:0] OPC_PROTECT = 8'hc2;
  localparam logic [7:0] OPC_SENSE = 8'h03;
  localparam logic [7:0] SUB_ON = 8'h0c;
  localparam logic [7:0] SUB_OFF = 8'h0d;
  localparam logic [7:0] SUB_PERM = 8'h0f;
  localparam logic [7:0] SUB_PW_ON = 8'h16;
  localparam logic [7:0] SUB_PW_OFF = 8'h17;
  localparam logic [7:0] SENSE_WP_CODE = 8'h27;
  localparam logic [7:0] STAT_OK = 8'h50;
  localparam logic [7:0] STAT_ERR = 8'h51;
  localparam logic [7:0] ERR_ABORT = 8'h04;
  localparam logic [7:0] ERR_NONE = 8'h00;
  localparam int ID_WORD_WP = 129;
  localparam int ID_BIT_WP = 8;
  localparam logic [31:0] PW_RESET = 32'h0000_0000;
  typedef enum logic [1:0] {
    WP_NORMAL,
    WP_PLAIN,
    WP_PASSWORD,
    WP_PERMANENT
  } wp_state_t;
endpackage

// ===== common/nv_if.sv
// Purpose: carries protection state between decoder and nonvolatile keeper
// Assumes: one clock domain
// Notes: save is a one-cycle pulse
interface nv_if;
  wp_cmd_pkg::wp_state_t saveState;
  logic [31:0] savePw;
  logic save;
  wp_cmd_pkg::wp_state_t loadState;
  logic [31:0] loadPw;
  logic loadValid;
  modport ctl (output saveState, output savePw, output save, input loadState, input loadPw, input loadValid);
  modport keep (input saveState, input savePw, input save, output loadState, output loadPw, output loadValid);
endinterface

// ===== src/wp_nv_keeper.sv
// Purpose: holds protection state and password across power cycles
// Assumes: nvState/nvPw inputs reflect the nonvolatile array, settled at power-up
// Notes: captured one cycle after reset release, never inside reset
module wp_nv_keeper (
  input wire logic clk,
  input wire logic rst,
  input wire logic [1:0] nvStateIn,
  input wire logic [31:0] nvPwIn,
  output logic nvWrite,
  output logic [1:0] nvStateOut,
  output logic [31:0] nvPwOut,
  nv_if.keep nv
);
  logic loaded_r;
  logic loaded_nxt;
  logic wr_r;
  logic wr_nxt;
  logic [1:0] st_r;
  logic [1:0] st_nxt;
  logic [31:0] pw_r;
  logic [31:0] pw_nxt;

  always_comb begin
    loaded_nxt = 1'b1;
    wr_nxt = nv.save;
    st_nxt = st_r;
    pw_nxt = pw_r;
    if (!loaded_r) begin
      st_nxt = nvStateIn;
      pw_nxt = nvPwIn;
    end else if (nv.save) begin
      st_nxt = 2'(nv.saveState);
      pw_nxt = nv.savePw;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      loaded_r <= 1'b0;
      wr_r <= 1'b0;
      st_r <= 2'h0;
      pw_r <= wp_cmd_pkg::PW_RESET;
    end else begin
      loaded_r <= loaded_nxt;
      wr_r <= wr_nxt;
      st_r <= st_nxt;
      pw_r <= pw_nxt;
    end
  end

  assign nvWrite = wr_r;
  assign nvStateOut = st_r;
  assign nvPwOut = pw_r;
  assign nv.loadState = wp_cmd_pkg::wp_state_t'(st_r);
  assign nv.loadPw = pw_r;
  assign nv.loadValid = loaded_r;
endmodule

// ===== tb/host_model.sv
// Purpose: host side that writes the taskfile and the command byte
// Assumes: called from the bench between falling edges
// Notes: only documented sub-functions are ever sent
module host_model (
  input wire logic clk,
  output logic cmdValid,
  output logic [7:0] cmdOpcode,
  output logic [7:0] featureReg,
  output logic [7:0] sectorCount,
  output logic [7:0] sectorNumber,
  output logic [7:0] cylLow,
  output logic [7:0] cylHigh
);
  timeunit 1ns;
  timeprecision 1ps;
  initial {cmdValid, cmdOpcode, featureReg, sectorCount, sectorNumber, cylLow, cylHigh} = '0;
  task automatic issue(input logic [7:0] op, input logic [7:0] sub, input logic [31:0] pw);
    @(negedge clk);
    cmdOpcode = op;
    sectorCount = sub;
    {cylHigh, cylLow, sectorNumber, featureReg} = pw;
    cmdValid = 1'b1;
    @(negedge clk);
    cmdValid = 1'b0;
    // stale password bytes inverted so they never pass as live
    {cylHigh, cylLow, sectorNumber, featureReg} = ~pw;
  endtask
endmodule

// ===== tb/write_protect_cmd_fsm_props.sv
// Purpose: port-level checks of the write-protect decoder
// Assumes: commands accepted from the 4th edge after reset release
// Notes: attached by bind below
module write_protect_cmd_fsm_props (
  input wire logic clk,
  input wire logic rst,
  input wire logic cmdValid,
  input wire logic [7:0] cmdOpcode,
  input wire logic cmdDone,
  input wire logic cmdHandled,
  input wire logic [7:0] statusOut,
  input wire logic [7:0] errorOut,
  input wire logic writeDiscard,
  input wire logic [15:0] identWord129,
  input wire logic protectActive,
  input wire logic [1:0] nvStateOut
);
  logic [2:0] bootCnt_r;
  logic [2:0] bootCnt_nxt;
  always_comb bootCnt_nxt = (bootCnt_r == 3'h7) ? bootCnt_r : bootCnt_r + 3'h1;
  always_ff @(posedge clk) bootCnt_r <= rst ? 3'h0 : bootCnt_nxt;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  chk_done_after_cmd: assert property (cmdValid && cmdOpcode == wp_cmd_pkg::OPC_PROTECT && bootCnt_r >= 3'h3
    |=> cmdDone) else $error("protect command not answered");
  chk_done_has_cause: assert property (cmdDone |-> $past(cmdValid)) else $error("done without command");
  chk_handled_pair: assert property (cmdHandled == cmdDone) else $error("handled differs from done");
  chk_ident_bit: assert property (identWord129 == {7'h00, protectActive, 8'h00})
    else $error("identify word wrong");
  chk_discard_level: assert property (writeDiscard == protectActive) else $error("discard differs");
  chk_error_keeps: assert property (cmdDone && statusOut == wp_cmd_pkg::STAT_ERR
    && $past(cmdOpcode) == wp_cmd_pkg::OPC_PROTECT |-> errorOut == wp_cmd_pkg::ERR_ABORT
    && protectActive == $past(protectActive)) else $error("error changed state");
  chk_perm_stays: assert property (nvStateOut == 2'h3 && bootCnt_r >= 3'h4 |-> protectActive)
    else $error("permanent state left");
  chk_status_holds: assert property (!cmdDone |-> $stable(statusOut) && $stable(errorOut))
    else $error("status moved without command");
endmodule
bind write_protect_cmd_fsm write_protect_cmd_fsm_props props (.clk, .rst, .cmdValid, .cmdOpcode, .cmdDone,
  .cmdHandled, .statusOut, .errorOut, .writeDiscard, .identWord129, .protectActive, .nvStateOut);

// ===== tb/test_write_protect_cmd_fsm.sv
// Purpose: self-checking bench for the write-protect decoder
// Assumes: host_model drives the taskfile; nv array modelled here
// Notes: expected state kept as plain integers
`define CHK(what, exp, got) begin cmp_count++; if ((got) !== (exp)) begin failures++; \
  $display("Error %s expected %h seen %h", what, exp, got); end end
module test_write_protect_cmd_fsm;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, rst, cmdValid, protectPinN, protectSwitchN, writeAborted, nvWrite, cmdDone, writeDiscard, protectActive;
  logic [7:0] cmdOpcode, featureReg, sectorCount, sectorNumber, cylLow, cylHigh, statusOut, errorOut;
  logic [1:0] nvSt, nvStateOut;
  logic [31:0] nvPw, nvPwOut, spw;
  logic [15:0] identWord129;
  int failures, cmp_count, st, hw;
  int codes[4] = '{12, 13, 22, 23};
  host_model host (.clk(clk), .cmdValid(cmdValid), .cmdOpcode(cmdOpcode), .featureReg(featureReg),
    .sectorCount(sectorCount), .sectorNumber(sectorNumber), .cylLow(cylLow), .cylHigh(cylHigh));
  write_protect_cmd_fsm dut (.clk(clk), .rst(rst), .cmdValid(cmdValid), .cmdOpcode(cmdOpcode),
    .featureReg(featureReg), .sectorCount(sectorCount), .sectorNumber(sectorNumber), .cylLow(cylLow),
    .cylHigh(cylHigh), .protectPinN(protectPinN), .protectSwitchN(protectSwitchN), .writeAborted(writeAborted),
    .nvStateIn(nvSt), .nvPwIn(nvPw), .nvWrite(nvWrite), .nvStateOut(nvStateOut), .nvPwOut(nvPwOut),
    .cmdDone(cmdDone), .cmdHandled(), .statusOut(statusOut), .errorOut(errorOut),
    .writeDiscard(writeDiscard), .identWord129(identWord129), .protectActive(protectActive));
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  always @(posedge clk) if (nvWrite) begin
    nvSt <= nvStateOut;
    nvPw <= nvPwOut;
  end
  task automatic results;
    $display("comparisons %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic boot;
    rst = 1'b1;
    repeat (2) @(negedge clk);
    rst = 1'b0;
    repeat (4) @(negedge clk);
  endtask
  task automatic prot(input int sub, input logic [31:0] p);
    int ns;
    logic err;
    logic pa;
    ns = st;
    err = 1'b0;
    case (st)
      0: if (sub == 12) ns = 1; else if (sub == 15) ns = 3; else if (sub == 22) begin
        ns = 2;
        spw = p;
      end
      1: if (sub == 13 || sub == 23) ns = 0;
      2: if (sub == 23 && p == spw) ns = 0; else if (sub == 13 || sub == 23) err = 1'b1;
      default: ns = st;
    endcase
    host.issue(wp_cmd_pkg::OPC_PROTECT, 8'(sub), p);
    st = ns;
    pa = st != 0 || hw != 0;
    `CHK("done", 1'b1, cmdDone)
    `CHK("status", err ? wp_cmd_pkg::STAT_ERR : wp_cmd_pkg::STAT_OK, statusOut)
    `CHK("error", err ? wp_cmd_pkg::ERR_ABORT : wp_cmd_pkg::ERR_NONE, errorOut)
    `CHK("protect", pa, protectActive)
    `CHK("ident", pa, identWord129[8])
    `CHK("discard", pa, writeDiscard)
  endtask
  initial begin
    #200000;
    failures++;
    results();
  end
  initial begin
    rst = 1'b1;
    protectPinN = 1'b1;
    protectSwitchN = 1'b1;
    hw = 0;
    writeAborted = 1'b0;
    nvSt = 2'h0;
    nvPw = '0;
    st = 0;
    spw = '0;
    void'($urandom(32'h7d56));
    boot();
    // late pin change must be ignored
    protectPinN = 1'b0;
    prot(13, 32'h0);
    host.issue(8'h11, 8'h0c, 32'h0);
    `CHK("unknown opcode", 1'b0, cmdDone)
    prot(12, 32'h0);
    prot(15, 32'h0);
    prot(22, 32'h0bad_0001);
    prot(23, 32'h0);
    prot(22, 32'h1234_5678);
    prot(13, 32'h0);
    prot(23, 32'h1234_5679);
    writeAborted = 1'b1;
    host.issue(wp_cmd_pkg::OPC_SENSE, 8'h00, 32'h0);
    `CHK("sense code", wp_cmd_pkg::SENSE_WP_CODE, errorOut)
    `CHK("sense status", wp_cmd_pkg::STAT_OK, statusOut)
    writeAborted = 1'b0;
    prot(12, 32'h0);
    // no abort since the last command, so no violation code
    host.issue(wp_cmd_pkg::OPC_SENSE, 8'h00, 32'h0);
    `CHK("sense clear", wp_cmd_pkg::ERR_NONE, errorOut)
    `CHK("sense done", 1'b1, cmdDone)
    prot(15, 32'h0);
    prot(22, 32'hffff_0000);
    prot(23, 32'h1234_5678);
    for (int i = 0; i < 40; i++) prot(codes[$urandom % 4], ($urandom % 2) ? spw : $urandom);
    protectPinN = 1'b1;
    repeat (2) @(negedge clk);
    boot();
    `CHK("after reboot", st != 0, protectActive)
    `CHK("nv state", 2'(st), nvStateOut)
    `CHK("nv password", spw, nvPwOut)
    if (st == 2) prot(23, spw); else prot(13, 32'h0);
    // strap low at power-up: pin first, then switch; released after sampling
    hw = 1;
    for (int k = 0; k < 2; k++) begin
      // let the last save reach the array before reset
      repeat (2) @(negedge clk);
      protectPinN = k[0];
      protectSwitchN = !k[0];
      boot();
      protectPinN = 1'b1;
      protectSwitchN = 1'b1;
      prot(13, 32'h0);
    end
    hw = 0;
    repeat (2) @(negedge clk);
    boot();
    prot(15, 32'h0);
    foreach (codes[i]) prot(codes[i], spw);
    results();
  end
endmodule
